// ### scm_adc_model.sv
// Purpose: Front-end converter stand-in giving fixed raw codes.
// Assumes: A code is sampled while its channel is selected.
// Notes: The unselected channel shows the inverted code.
module scm_adc_model #(
   parameter logic [23:0] P_S = 24'h080000,
   parameter logic [23:0] P_T = 24'h000056
) (
   input wire logic i_sel,
   output logic [23:0] o_sensor,
   output logic [23:0] o_temp
);
   timeunit 1ns;
   timeprecision 1ps;
   // Codes are only good on the channel in conversion
   assign o_sensor = i_sel ? ~P_S : P_S;
   assign o_temp = i_sel ? P_T : ~P_T;
endmodule

// ### scm_calib_math.sv
// Purpose: Conversion timing and fixed-point correction datapath for sensor and temperature.
// Assumes: ADC raw values are valid whenever a conversion period ends.
// Notes: One arithmetic step per clock; inversion uses a bit-serial divider.
module scm_calib_math #(
   parameter int P_CYC_PER_US = scm_pkg::SCM_CYC_PER_US
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [scm_pkg::SCM_AW-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [23:0] i_adc_sensor,
   input wire logic [23:0] i_adc_temp,
   output logic [31:0] o_rdata,
   output logic o_adc_start,
   output logic o_adc_temp_sel,
   output logic [4:0] o_adc_bits,
   output logic o_noise_mode,
   output logic o_busy,
   output logic o_done
);
   import scm_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_CONV_S, ST_CONV_T, ST_INV, ST_MATH} scm_state_t;

   typedef struct packed {
      scm_state_t state;
      logic [1:0] cfg_res;
      logic cfg_noise;
      logic cfg_inv;
      logic cfg_shape;
      logic cfg_written;
      logic [SCM_NCOEF-1:0][23:0] coef;
      logic busy;
      logic raw_mode;
      logic sat;
      logic done;
      logic adc_start;
      logic adc_temp_sel;
      logic [4:0] adc_bits;
      logic [15:0] tmr_pre;
      logic [13:0] tmr_us;
      logic signed [25:0] raw_s;
      logic signed [25:0] raw_t;
      logic signed [25:0] k1;
      logic signed [25:0] k2;
      logic signed [25:0] z;
      logic signed [25:0] acc;
      logic [3:0] step;
      logic [46:0] dq;
      logic [24:0] drem;
      logic [5:0] dcnt;
      logic [23:0] res_s;
      logic [23:0] res_t;
      logic [31:0] rdata;
   } scm_regs_t;

   scm_regs_t q;
   scm_regs_t n;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Sign-magnitude coefficient to 26-bit working value, magnitude limited
   function automatic logic signed [63:0] coef_w(input logic [23:0] c, input int idx);
      logic [22:0] mag;
      logic [22:0] lim;
      logic signed [63:0] v;
      lim = SCM_MAG_WIDE;
      if ((idx >= SCM_C_TCG && idx <= SCM_C_SO_S) || idx == SCM_C_SO_T)
      begin
         lim = SCM_MAG_NARROW;
      end
      mag = (c[22:0] > lim) ? lim : c[22:0];
      v = {39'h0, mag, 2'h0};
      coef_w = c[23] ? -v : v;
   endfunction

   // Product scaled down by two to the 23
   function automatic logic signed [63:0] mul(input logic signed [63:0] a, input logic signed [63:0] b);
      mul = (a * b) >>> SCM_FRAC;
   endfunction

   // Clamp into [lo, hi]; top bit flags that clamping happened
   function automatic logic [26:0] clamp(input logic signed [63:0] v, input logic signed [63:0] lo,
                                         input logic signed [63:0] hi);
      if (v > hi)
      begin
         clamp = {1'b1, hi[25:0]};
      end
      else if (v < lo)
      begin
         clamp = {1'b1, lo[25:0]};
      end
      else
      begin
         clamp = {1'b0, v[25:0]};
      end
   endfunction

   // Sensor conversion length in microseconds
   function automatic logic [13:0] conv_s_us(input logic [1:0] res, input logic noise);
      unique case (res)
         2'h0: conv_s_us = noise ? SCM_US_S12_HI : SCM_US_S12_LO;
         2'h1: conv_s_us = noise ? SCM_US_S14_HI : SCM_US_S14_LO;
         2'h2: conv_s_us = noise ? SCM_US_S16_HI : SCM_US_S16_LO;
         2'h3: conv_s_us = noise ? SCM_US_S18_HI : SCM_US_S18_LO;
      endcase
   endfunction

   // Temperature conversion length in microseconds
   function automatic logic [13:0] conv_t_us(input logic [1:0] res);
      unique case (res)
         2'h0: conv_t_us = SCM_US_T12;
         2'h1: conv_t_us = SCM_US_T14;
         2'h2: conv_t_us = SCM_US_T16;
         2'h3: conv_t_us = SCM_US_T18;
      endcase
   endfunction

   // Sensor resolution in bits from the select field
   function automatic logic [4:0] sens_bits(input logic [1:0] res);
      sens_bits = SCM_BITS_BASE + {2'h0, res, 1'b0};
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic [26:0] r;
   logic [1:0] dst;
   logic tick;
   logic [24:0] rem2;
   logic qbit;
   logic [46:0] qf;
   logic signed [63:0] zabs;
   logic signed [63:0] inv;
   logic [5:0] cidx;

   always_comb
   begin
      n = q;
      r = '0;
      dst = 2'h0;
      rem2 = '0;
      qbit = 1'b0;
      qf = '0;
      inv = '0;
      zabs = (q.z < 0) ? -64'(q.z) : 64'(q.z);
      cidx = 6'((i_addr - SCM_A_COEF0) >> 2);
      tick = (q.tmr_pre == 16'h0);
      n.adc_start = 1'b0;
      n.done = 1'b0;
      n.rdata = '0;
      n.tmr_pre = tick ? 16'(P_CYC_PER_US - 1) : q.tmr_pre - 16'h1;
      // Register writes
      if (i_wr)
      begin
         if (i_addr == SCM_A_CONFIG)
         begin
            n.cfg_res = i_wdata[SCM_F_RES +: 2];
            n.cfg_noise = i_wdata[SCM_F_NOISE];
            n.cfg_inv = i_wdata[SCM_F_INV];
            n.cfg_shape = i_wdata[SCM_F_SHAPE];
            n.cfg_written = 1'b1;
         end
         else if (i_addr >= SCM_A_COEF0 && i_addr[1:0] == 2'h0 && cidx < 6'(SCM_NCOEF))
         begin
            n.coef[cidx] = i_wdata[23:0];
         end
         else if (i_addr == SCM_A_CTRL && !q.busy)
         begin
            if (i_wdata[SCM_F_MEAS] || i_wdata[SCM_F_RAW])
            begin
               n.raw_mode = !i_wdata[SCM_F_MEAS];
               n.busy = 1'b1;
               n.sat = 1'b0;
               n.state = ST_CONV_S;
               n.tmr_us = conv_s_us(q.cfg_res, q.cfg_noise);
               n.tmr_pre = 16'(P_CYC_PER_US - 1);
               n.adc_start = 1'b1;
               n.adc_temp_sel = 1'b0;
               n.adc_bits = sens_bits(q.cfg_res);
            end
            else if (i_wdata[SCM_F_NOP])
            begin
               n.sat = 1'b0;
               n.raw_mode = 1'b0;
            end
         end
      end
      // Register reads, data in the following cycle
      if (i_rd)
      begin
         if (i_addr == SCM_A_CONFIG)
         begin
            n.rdata[SCM_F_RES +: 2] = q.cfg_res;
            n.rdata[SCM_F_NOISE] = q.cfg_noise;
            n.rdata[SCM_F_INV] = q.cfg_inv;
            n.rdata[SCM_F_SHAPE] = q.cfg_shape;
         end
         else if (i_addr == SCM_A_STATUS)
         begin
            n.rdata[SCM_F_PWR] = 1'b1;
            n.rdata[SCM_F_BUSY] = q.busy;
            n.rdata[SCM_F_MODE] = q.raw_mode;
            n.rdata[SCM_F_SAT] = q.sat;
         end
         else if (i_addr == SCM_A_RES_S)
         begin
            n.rdata[23:0] = q.res_s;
         end
         else if (i_addr == SCM_A_RES_T)
         begin
            n.rdata[23:0] = q.res_t;
         end
         else if (i_addr == SCM_A_RAW_S)
         begin
            n.rdata[23:0] = q.raw_s[23:0];
         end
         else if (i_addr == SCM_A_RAW_T)
         begin
            n.rdata[23:0] = q.raw_t[23:0];
         end
         else if (i_addr >= SCM_A_COEF0 && i_addr[1:0] == 2'h0 && cidx < 6'(SCM_NCOEF))
         begin
            n.rdata[23:0] = q.coef[cidx];
         end
      end
      // Sequencer
      unique case (q.state)
         ST_IDLE:
         begin
         end
         ST_CONV_S:
         begin
            if (tick)
            begin
               n.tmr_us = q.tmr_us - 14'h1;
               if (q.tmr_us == 14'h1)
               begin
                  n.raw_s = 26'(signed'(i_adc_sensor));
                  n.state = ST_CONV_T;
                  n.tmr_us = conv_t_us(q.cfg_res);
                  n.adc_start = 1'b1;
                  n.adc_temp_sel = 1'b1;
                  n.adc_bits = SCM_TEMP_BITS;
               end
            end
         end
         ST_CONV_T:
         begin
            if (tick)
            begin
               n.tmr_us = q.tmr_us - 14'h1;
               if (q.tmr_us == 14'h1)
               begin
                  n.raw_t = 26'(signed'(i_adc_temp));
                  n.step = 4'h0;
                  if (q.raw_mode)
                  begin
                     // Raw command: no inversion, no correction
                     n.res_s = q.raw_s[23:0];
                     n.res_t = i_adc_temp;
                     n.busy = 1'b0;
                     n.done = 1'b1;
                     n.state = ST_IDLE;
                  end
                  else if (q.cfg_inv && q.raw_s == 26'sh0)
                  begin
                     n.raw_s = SCM_LO26[25:0];
                     n.sat = 1'b1;
                     n.state = ST_MATH;
                  end
                  else if (q.cfg_inv)
                  begin
                     n.k2 = (q.raw_s < 0) ? -q.raw_s : q.raw_s;
                     n.dq = '0;
                     n.drem = '0;
                     n.dcnt = SCM_DIV_TOP;
                     n.state = ST_INV;
                  end
                  else
                  begin
                     n.state = ST_MATH;
                  end
               end
            end
         end
         ST_INV:
         begin
            // Long division of 2^46 by the raw magnitude, one bit per cycle
            rem2 = {q.drem[23:0], (q.dcnt == SCM_DIV_TOP)};
            qbit = (rem2 >= 25'(q.k2));
            n.drem = qbit ? rem2 - 25'(q.k2) : rem2;
            qf = {q.dq[45:0], qbit};
            n.dq = qf;
            n.dcnt = q.dcnt - 6'h1;
            if (q.dcnt == 6'h0)
            begin
               inv = (q.raw_s < 0) ? SCM_TWO24 + 64'(qf) : SCM_TWO24 - 64'(qf);
               r = clamp(inv, SCM_LO26, SCM_HI26);
               n.raw_s = r[25:0];
               n.sat = q.sat | r[26];
               n.state = ST_MATH;
            end
         end
         ST_MATH:
         begin
            n.step = q.step + 4'h1;
            unique case (q.step)
               4'h0: {dst, r} = {2'h3, clamp(mul(coef_w(q.coef[SCM_C_SO_TCG], SCM_C_SO_TCG), 64'(q.raw_t)),
                                             SCM_LO26, SCM_HI26)};
               4'h1: {dst, r} = {2'h0, clamp(SCM_ONE + mul(64'(q.raw_t), 64'(q.acc)
                                             + coef_w(q.coef[SCM_C_TCG], SCM_C_TCG)), SCM_LO26, SCM_HI26)};
               4'h2: {dst, r} = {2'h3, clamp(mul(coef_w(q.coef[SCM_C_SO_TCO], SCM_C_SO_TCO), 64'(q.raw_t)),
                                             SCM_LO26, SCM_HI26)};
               4'h3: {dst, r} = {2'h1, clamp(coef_w(q.coef[SCM_C_OFF_S], SCM_C_OFF_S) + 64'(q.raw_s)
                                             + mul(64'(q.raw_t), 64'(q.acc) + coef_w(q.coef[SCM_C_TCO], SCM_C_TCO)),
                                             SCM_LO26, SCM_HI26)};
               4'h4: {dst, r} = {2'h3, clamp(q.cfg_shape ? mul(64'(q.k1), 64'(q.k2))
                                             : mul(coef_w(q.coef[SCM_C_GAIN_S], SCM_C_GAIN_S), 64'(q.k1)),
                                             SCM_LO26, SCM_HI26)};
               4'h5:
               begin
                  if (q.cfg_shape)
                  begin
                     {dst, r} = {2'h2, clamp(mul(coef_w(q.coef[SCM_C_GAIN_S], SCM_C_GAIN_S), 64'(q.acc)),
                                             SCM_LO26, SCM_HI26)};
                  end
                  else
                  begin
                     {dst, r} = {2'h2, clamp(mul(64'(q.acc), 64'(q.k2)) + SCM_ONE, SCM_ZERO, SCM_HI26)};
                  end
               end
               4'h6: {dst, r} = {2'h3, clamp(mul(coef_w(q.coef[SCM_C_SO_S], SCM_C_SO_S),
                                             q.cfg_shape ? zabs : 64'(q.z)) + SCM_ONE, SCM_LO26, SCM_HI26)};
               4'h7: {dst, r} = {2'h0, clamp(mul(64'(q.z), 64'(q.acc)) + coef_w(q.coef[SCM_C_SHIFT_S], SCM_C_SHIFT_S)
                                             + (q.cfg_shape ? SCM_ONE : SCM_ZERO), SCM_ZERO, SCM_S_MAX)};
               4'h8: {dst, r} = {2'h3, clamp(64'(q.raw_t) + coef_w(q.coef[SCM_C_OFF_T], SCM_C_OFF_T),
                                             SCM_LO26, SCM_HI26)};
               4'h9: {dst, r} = {2'h2, clamp(mul(coef_w(q.coef[SCM_C_GAIN_T], SCM_C_GAIN_T), 64'(q.acc))
                                             + SCM_ONE, SCM_ZERO, SCM_HI26)};
               4'hA: {dst, r} = {2'h3, clamp(mul(coef_w(q.coef[SCM_C_SO_T], SCM_C_SO_T), 64'(q.z)) + SCM_ONE,
                                             SCM_LO26, SCM_HI26)};
               default: {dst, r} = {2'h1, clamp(mul(64'(q.z), 64'(q.acc))
                                                + coef_w(q.coef[SCM_C_SHIFT_T], SCM_C_SHIFT_T),
                                                SCM_ZERO, SCM_T_MAX)};
            endcase
            n.sat = q.sat | r[26];
            unique case (dst)
               2'h0: n.k1 = r[25:0];
               2'h1: n.k2 = r[25:0];
               2'h2: n.z = r[25:0];
               2'h3: n.acc = r[25:0];
            endcase
            if (q.step == 4'hB)
            begin
               // Both results change in the same cycle
               n.res_s = q.k1[23:0];
               n.res_t = r[23:0];
               n.busy = 1'b0;
               n.done = 1'b1;
               n.state = ST_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         q <= '0;
         q.cfg_res <= SCM_RES_RST;
         q.adc_bits <= SCM_BITS_BASE;
      end
      else
      begin
         q <= n;
      end
   end

   // Outputs straight from the state register
   assign o_rdata = q.rdata;
   assign o_adc_start = q.adc_start;
   assign o_adc_temp_sel = q.adc_temp_sel;
   assign o_adc_bits = q.adc_bits;
   assign o_noise_mode = q.cfg_noise;
   assign o_busy = q.busy;
   assign o_done = q.done;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_temp_bits_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      q.adc_start && q.adc_temp_sel |-> q.adc_bits == SCM_TEMP_BITS)
      else $error("temperature conversion not at 14 bits");
   a_sens_bits_map: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      q.adc_start && !q.adc_temp_sel |-> q.adc_bits == sens_bits($past(q.cfg_res)))
      else $error("sensor resolution does not follow select field");
   a_res_default: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !q.cfg_written |-> q.cfg_res == SCM_RES_RST)
      else $error("resolution default is not 16 bits");
   a_noise_longer: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      q.adc_start && !q.adc_temp_sel && $past(q.cfg_noise) |-> q.tmr_us > conv_s_us($past(q.cfg_res), 1'b0))
      else $error("high noise mode not longer");
   a_sens_time_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      q.adc_start && !q.adc_temp_sel |-> q.tmr_us == conv_s_us($past(q.cfg_res), $past(q.cfg_noise)))
      else $error("sensor conversion length wrong");
   a_temp_time_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      q.adc_start && q.adc_temp_sel |-> q.tmr_us == conv_t_us($past(q.cfg_res)))
      else $error("temperature conversion length wrong");
   a_raw_bypass: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      q.done && q.raw_mode |-> q.res_s == q.raw_s[23:0] && !q.sat)
      else $error("raw measurement was altered");
   a_sens_range: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      q.done && !q.raw_mode |-> 64'(q.res_s) <= SCM_S_MAX)
      else $error("sensor result out of range");
   a_sat_nop_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_wr && i_addr == SCM_A_CTRL && !q.busy && i_wdata[2:0] == 3'h4 |=> !q.sat)
      else $error("saturation flag not cleared by non-measurement command");
   a_results_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !n.done |=> $stable(q.res_s) && $stable(q.res_t))
      else $error("results changed outside measurement completion");
endmodule

// ### scm_pkg.sv
// Purpose: Shared constants for the sensor calibration math block.
// Assumes: 200 MHz system clock, registers reached over a plain strobe port.
// Notes: Coefficients are written by software in 24-bit sign-magnitude form.
//
// What this block does
// - Temperature conversions always run at 14-bit resolution.
// - Two-bit resolution field selects 12, 14, 16 or 18 sensor bits.
// - Sensor resolution defaults to 16 bits after reset.
// - Noise select bit picks front-end mode; high mode lengthens sensor conversion.
// - Sensor conversion lasts 770/1310/2390/4550 us, high-noise up to 10620 us.
// - Temperature conversion lasts 630/1040/1810/3470 us by resolution field.
// - Correction arithmetic is 26-bit two's complement.
// - Coefficients are 24-bit sign-magnitude: sign bit plus 23-bit magnitude.
// - Every product is divided by two to the 23.
// - Overflow or underflow clamps to the bound and flags saturation.
// - Pre-inversion applies only to compensated measurements, never raw ones.
// - Pre-inversion gives 2^24 minus 2^46 over raw, clamped to 26 bits.
// - Shape bit selects parabolic (0) or S-shaped (1) sensor correction.
// - Coefficients load shifted left two bits into 26-bit registers.
// - K1 and K2 combine raw temperature tempco terms as specified.
// - Parabolic Z and output use gain, second-order term, shift, clamped positive.
// - S-shaped Z clamps each product; output uses absolute Z plus offsets.
// - Corrected sensor result is non-negative and at most FFFFF hex.
// - Temperature correction is always parabolic with gain, offset, shift.
// - Gain/offset magnitude up to 7FFFFF; tempco and second-order up to 7FFFF.
// - Saturation status is set by measurement saturation, cleared otherwise.
package scm_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int SCM_AW = 8;
   localparam logic [7:0] SCM_A_CONFIG = 8'h00;
   localparam logic [7:0] SCM_A_CTRL = 8'h04;
   localparam logic [7:0] SCM_A_STATUS = 8'h08;
   localparam logic [7:0] SCM_A_RES_S = 8'h0C;
   localparam logic [7:0] SCM_A_RES_T = 8'h10;
   localparam logic [7:0] SCM_A_RAW_S = 8'h14;
   localparam logic [7:0] SCM_A_RAW_T = 8'h18;
   localparam logic [7:0] SCM_A_COEF0 = 8'h20;
   localparam int SCM_NCOEF = 12;
   // Config field positions and reset values
   localparam int SCM_F_RES = 6;
   localparam int SCM_F_NOISE = 8;
   localparam int SCM_F_INV = 11;
   localparam int SCM_F_SHAPE = 15;
   localparam logic [1:0] SCM_RES_RST = 2'h2;
   // Control command bits
   localparam int SCM_F_MEAS = 0;
   localparam int SCM_F_RAW = 1;
   localparam int SCM_F_NOP = 2;
   // Status bit positions
   localparam int SCM_F_SAT = 0;
   localparam int SCM_F_MODE = 3;
   localparam int SCM_F_BUSY = 5;
   localparam int SCM_F_PWR = 6;
   // Coefficient indices
   localparam int SCM_C_GAIN_S = 0;
   localparam int SCM_C_OFF_S = 1;
   localparam int SCM_C_TCG = 2;
   localparam int SCM_C_TCO = 3;
   localparam int SCM_C_SO_TCG = 4;
   localparam int SCM_C_SO_TCO = 5;
   localparam int SCM_C_SO_S = 6;
   localparam int SCM_C_SHIFT_S = 7;
   localparam int SCM_C_GAIN_T = 8;
   localparam int SCM_C_OFF_T = 9;
   localparam int SCM_C_SO_T = 10;
   localparam int SCM_C_SHIFT_T = 11;
   localparam logic [22:0] SCM_MAG_WIDE = 23'h7FFFFF;
   localparam logic [22:0] SCM_MAG_NARROW = 23'h07FFFF;
   // ----------------------------------------------------------------
   // Arithmetic bounds
   // ----------------------------------------------------------------
   localparam int SCM_FRAC = 23;
   localparam logic signed [63:0] SCM_HI26 = 64'sh1FFFFFF;
   localparam logic signed [63:0] SCM_LO26 = -64'sh2000000;
   localparam logic signed [63:0] SCM_ZERO = 64'sh0;
   localparam logic signed [63:0] SCM_ONE = 64'sh800000;
   localparam logic signed [63:0] SCM_TWO24 = 64'sh1000000;
   localparam logic signed [63:0] SCM_S_MAX = 64'shFFFFF;
   localparam logic signed [63:0] SCM_T_MAX = 64'shFFFFFF;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SCM_CLK_MHZ = 200;
   localparam int SCM_CYC_PER_US = SCM_CLK_MHZ;
   localparam logic [4:0] SCM_TEMP_BITS = 5'h0E;
   localparam logic [4:0] SCM_BITS_BASE = 5'h0C;
   localparam logic [13:0] SCM_US_S12_LO = 14'd770;
   localparam logic [13:0] SCM_US_S14_LO = 14'd1310;
   localparam logic [13:0] SCM_US_S16_LO = 14'd2390;
   localparam logic [13:0] SCM_US_S18_LO = 14'd4550;
   localparam logic [13:0] SCM_US_S12_HI = 14'd1550;
   localparam logic [13:0] SCM_US_S14_HI = 14'd2850;
   localparam logic [13:0] SCM_US_S16_HI = 14'd5440;
   localparam logic [13:0] SCM_US_S18_HI = 14'd10620;
   localparam logic [13:0] SCM_US_T12 = 14'd630;
   localparam logic [13:0] SCM_US_T14 = 14'd1040;
   localparam logic [13:0] SCM_US_T16 = 14'd1810;
   localparam logic [13:0] SCM_US_T18 = 14'd3470;
   localparam logic [5:0] SCM_DIV_TOP = 6'd46;
endpackage

// ### tb.sv
// Purpose: Self-checking bench for the calibration math block.
// Assumes: One clock per microsecond tick.
// Notes: Coefficients make the sensor result equal its raw code.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import scm_pkg::*;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, sel, start, busy, done, noise;
   logic [7:0] addr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [23:0] adc_s, adc_t;
   logic [4:0] bits;
   int failures = 0, check_count = 0;
   logic [31:0] cfg [5] = '{32'h0, 32'h40, 32'h80, 32'hC0, 32'h1C0};
   int ls [5] = '{770, 1310, 2390, 4550, 10620};
   int lt [5] = '{630, 1040, 1810, 3470, 3470};
   scm_calib_math #(.P_CYC_PER_US(1)) scm_calib_math_i (.i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_adc_sensor(adc_s), .i_adc_temp(adc_t), .o_rdata(rdata),
      .o_adc_start(start), .o_adc_temp_sel(sel), .o_adc_bits(bits), .o_noise_mode(noise),
      .o_busy(busy), .o_done(done));
   scm_adc_model scm_adc_model_i (.i_sel(sel), .o_sensor(adc_s), .o_temp(adc_t));
   // Clock
   initial
      forever #2.5 clk = ~clk;
   // Compare and count
   task automatic chk(string n, logic [31:0] s, e);
      check_count++;
      if (s !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bus write and checked read
   task automatic wrt(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(string n, logic [7:0] a, logic [31:0] m, e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(n, rdata & m, e);
   endtask
   // Run one command; time the sensor conversion, and the temperature one for raw commands only
   task automatic meas(logic [31:0] cmd, int s, t, logic [4:0] b);
      int n;
      wrt(SCM_A_CTRL, cmd);
      #1 chk("bits", bits, b);
      chk("start", start, 1'b1);
      chk("busy", busy, 1'b1);
      n = 0;
      while (sel !== 1'b1 && n < 20000)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("s_time", n >= s - 1 && n <= s + 2, 32'h1);
      chk("t_bits", bits, 32'h0E);
      chk("t_start", start, 1'b1);
      n = 0;
      while (done !== 1'b1 && n < 20000)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("busy_end", busy, 1'b0);
      if (cmd == 32'h2)
         chk("t_time", n >= t - 1 && n <= t + 2, 32'h1);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rdc("res", SCM_A_CONFIG, 32'hC0, 32'h80);
      for (int i = 0; i < SCM_NCOEF; i++)
         wrt(SCM_A_COEF0 + 8'(4 * i), i == 0 ? 32'h200000 : i == 7 ? 32'hA00000 : 32'h0);
      // High address must not alias a loaded coefficient
      rdc("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         wrt(SCM_A_CONFIG, cfg[i]);
         meas(32'h2, ls[i], lt[i], 5'(12 + 2 * cfg[i][7:6]));
         chk("noise", noise, cfg[i][8]);
      end
      wrt(SCM_A_CONFIG, 32'h80);
      meas(32'h1, 2390, 1810, 5'h10);
      rdc("res_s", SCM_A_RES_S, 32'hFFFFFFFF, 32'h080000);
      rdc("res_t", SCM_A_RES_T, 32'hFFFFFFFF, 32'h800000);
      rdc("stat", SCM_A_STATUS, 32'h61, 32'h40);
      wrt(SCM_A_CONFIG, 32'h880);
      meas(32'h1, 2390, 1810, 5'h10);
      rdc("inv_s", SCM_A_RES_S, 32'hFFFFFFFF, 32'h0);
      rdc("sat", SCM_A_STATUS, 32'h1, 32'h1);
      wrt(SCM_A_CTRL, 32'h4);
      rdc("nop_sat", SCM_A_STATUS, 32'h1, 32'h0);
      meas(32'h2, 2390, 1810, 5'h10);
      rdc("raw_s", SCM_A_RAW_S, 32'hFFFFFF, 32'h080000);
      rdc("raw_res_s", SCM_A_RES_S, 32'hFFFFFF, 32'h080000);
      rdc("raw_res_t", SCM_A_RES_T, 32'hFFFFFF, 32'h000056);
      // S-shaped curve with an over-range second-order term
      wrt(SCM_A_COEF0 + 8'h18, 32'h7FFFFF);
      wrt(SCM_A_CONFIG, 32'h8080);
      meas(32'h1, 2390, 1810, 5'h10);
      rdc("shape_s", SCM_A_RES_S, 32'hFFFFFFFF, 32'h081FFF);
      rdc("shape_t", SCM_A_RES_T, 32'hFFFFFFFF, 32'h800000);
      rdc("shape_sat", SCM_A_STATUS, 32'h1, 32'h0);
      finish_test;
   end
   // Watchdog
   initial
   begin
      #400000;
      failures++;
      finish_test;
   end
endmodule
